// ### dv/phy_misc_partner.sv
// far-end cable model: echo timing for reflectometry, forced speed mode
`timescale 1ns/1ps
module phy_misc_partner (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [7:0] dly,
    input  wire logic       fail_req,
    input  wire logic       forced_req,
    output logic            finished,
    output logic            failed,
    output logic            forced_100
);
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cnt <= 8'h00;
        else if (!run)
            cnt <= 8'h00;
        else if (cnt != 8'hFF)
            cnt <= cnt + 8'h01;
    end
    assign finished = run && cnt == dly;
    // result line is only meaningful with the pulse, so it wanders otherwise
    assign failed = finished ? fail_req : cnt[0];
    assign forced_100 = forced_req;
endmodule

// ### dv/phy_misc_regs_props.sv
// concurrent checks on the phy miscellaneous register bank ports
`timescale 1ns/1ps
module phy_misc_regs_props (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        IEEE_FULL_DUPLEX,
    input wire logic        PARTNER_FORCED_100,
    input wire logic        IRQ_EVENT,
    input wire logic        LINK_UP,
    input wire logic        TDR_FINISHED,
    input wire logic        PAD_OUT,
    input wire logic        PAD_OE,
    input wire logic        POWER_DOWN,
    input wire logic        FULL_DUPLEX,
    input wire logic        MDI_CROSSED,
    input wire logic        TDR_RUN,
    input wire logic [3:0]  TEST_PAIR_EN,
    input wire logic        SOFT_RESET,
    input wire logic        SOFT_RESTART
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic take = WB_CYC_I & WB_STB_I & !WB_ACK_O;
    wire logic wr   = take & WB_WE_I;
    wire logic go   = wr & WB_ADR_I == 8'h78 & WB_SEL_I[0] & WB_DAT_I[0];
    wire logic srst = wr & WB_ADR_I == 8'h7C & WB_SEL_I[1] & WB_DAT_I[15];
    wire logic srest = wr & WB_ADR_I == 8'h7C & WB_SEL_I[1] & WB_DAT_I[14];
    wire logic rd_phy_configuration_three = take & !WB_WE_I & WB_ADR_I == 8'h78;
    wire logic rd_ctrl = take & !WB_WE_I & WB_ADR_I == 8'h7C;
    // outputs still hold reset values at the first edge after release
    a_fdx_ieee: assert property (!$past(RST) && $past(IEEE_FULL_DUPLEX)
        |-> FULL_DUPLEX) else $error("full duplex missing");
    a_fdx_none: assert property (!$past(IEEE_FULL_DUPLEX)
        && !$past(PARTNER_FORCED_100) |-> !FULL_DUPLEX)
        else $error("full duplex without cause");
    a_pad_role: assert property (POWER_DOWN |-> !PAD_OE)
        else $error("power down while pad drives");
    a_irq_event: assert property (!$past(RST) && $past(IRQ_EVENT)
        |-> !PAD_OUT) else $error("interrupt not asserted");
    a_tdr_launch: assert property ($rose(TDR_RUN) |-> $past(go))
        else $error("run started without launch write");
    a_tdr_finish: assert property (TDR_RUN && TDR_FINISHED
        |=> !TDR_RUN) else $error("run outlived finish");
    a_soft_reset: assert property (SOFT_RESET
        |-> $past(srst, 2) ##1 !SOFT_RESET) else $error("bad soft reset");
    a_soft_restart: assert property (SOFT_RESTART
        |-> $past(srest, 2) ##1 !SOFT_RESTART) else $error("bad restart");
    a_pair_sel: assert property (!$past(RST) |->
        $onehot(TEST_PAIR_EN) || TEST_PAIR_EN == 4'hF)
        else $error("pair enables malformed");
    a_rsvd_ctrl: assert property (WB_ACK_O && $past(rd_ctrl)
        |-> WB_DAT_O[13:0] == 14'h0) else $error("ctrl reserved set");
    a_rsvd_phy_configuration_three: assert property (WB_ACK_O && $past(rd_phy_configuration_three)
        |-> WB_DAT_O[5:3] == 3'h0 && !WB_DAT_O[10])
        else $error("phy_configuration_three reserved set");
    a_hunt_link: assert property ($changed(MDI_CROSSED)
        |-> !$past(LINK_UP) || SOFT_RESET || SOFT_RESTART
        || $past(SOFT_RESET) || $past(SOFT_RESTART))
        else $error("crossover moved with link up");
    c_launch: cover property ($rose(TDR_RUN));
    c_reset: cover property (SOFT_RESET);
    c_all_pairs: cover property (TEST_PAIR_EN == 4'hF);
    c_hunt: cover property ($changed(MDI_CROSSED));
endmodule
bind phy_misc_regs phy_misc_regs_props u_props (.CLK, .RST, .WB_CYC_I,
    .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O,
    .WB_ACK_O, .IEEE_FULL_DUPLEX, .PARTNER_FORCED_100, .IRQ_EVENT,
    .LINK_UP, .TDR_FINISHED, .PAD_OUT, .PAD_OE, .POWER_DOWN, .FULL_DUPLEX,
    .MDI_CROSSED, .TDR_RUN, .TEST_PAIR_EN, .SOFT_RESET, .SOFT_RESTART);

// ### dv/test_phy_misc_config_control_regs.sv
// self-checking bench for the phy miscellaneous register bank
`timescale 1ns/1ps
module test_phy_misc_config_control_regs;
    localparam int RS = 8;
    localparam int NH = 20;
    localparam int QH = 3;
    logic        clk, rst, cyc, stb, we, an, f100, ieee, link, irq;
    logic        pad_in, fail_req, forced_req, fin, fld, pf;
    logic        ack, pad_out, pad_oe, pdown, fdx, mdi, run, s_rst, s_rest;
    logic [7:0]  adr, dly;
    logic [3:0]  sel, lanes, pairs;
    logic [31:0] wdat, rdat, note, r;
    logic [31:0] q[$];
    int          fail_count, n_compared, seed;
    phy_misc_regs #(.ROBUST_STEP(RS), .NORMAL_HUNT(NH), .QUICK_HUNT(QH))
    u_dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .LOCAL_AUTONEG(an),
        .LOCAL_FORCED_100(f100), .PARTNER_FORCED_100(pf),
        .IEEE_FULL_DUPLEX(ieee), .LINK_UP(link), .IRQ_EVENT(irq),
        .TDR_FINISHED(fin), .TDR_FAILED(fld), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe), .POWER_DOWN(pdown),
        .FULL_DUPLEX(fdx), .MDI_CROSSED(mdi), .TDR_RUN(run),
        .TEST_PAIR_EN(pairs), .SOFT_RESET(s_rst), .SOFT_RESTART(s_rest));
    phy_misc_partner u_far (.clk(clk), .rst(rst), .run(run), .dly(dly),
        .fail_req(fail_req), .forced_req(forced_req), .finished(fin),
        .failed(fld), .forced_100(pf));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // e packs the read mask above the expected value
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [15:0] d, input logic [31:0] e = 32'h0);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= {16'h0000, d};
        if (!w) q.push_back(e);
        n = 0;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            note = q.pop_front();
            chk(rdat[15:0] & note[31:16], note[15:0]);
        end
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // measures a whole toggle interval; the first one may be partial
    task automatic hunt_period(input int e);
        int n;
        logic p;
        n = 0;
        @(posedge clk);
        p = mdi;
        while (mdi === p && n < 100) begin @(posedge clk); n++; end
        if (n < 100) begin
            p = mdi;
            n = 0;
            while (mdi === p && n < 100) begin @(posedge clk); n++; end
        end
        chk(n >= 100 ? 16'h0 : 16'(n), 16'(e));
    endtask
    initial begin
        {rst, lanes, seed} = {1'b1, 4'h3, 32'h30BC};
        {cyc, stb, we, adr, sel, wdat, an, f100, ieee, irq} = '0;
        {link, pad_in, fail_req, forced_req, dly} = {4'hA, 8'h06};
        {fail_count, n_compared} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(0, 8'h78, 0, 32'hFFFF_0002);
        wb(0, 8'h7C, 0, 32'hFFFF_0000);
        wb(0, 8'h94, 0, 32'hFFFF_0400);
        wb(0, 8'hB0, 0, 32'hFFFF_141F);
        wb(0, 8'h40, 0, 32'hFFFF_0000);
        $display("reset values done");
        lanes = 4'h1;
        wb(1, 8'h78, 16'h0800);
        wb(0, 8'h78, 0, 32'hFFFF_0002);
        lanes = 4'h3;
        wb(1, 8'h78, 16'hFFFE);
        wb(0, 8'h78, 0, 32'hFFFF_0BC2);
        wb(1, 8'h7C, 16'h3FFF);
        wb(1, 8'h40, 16'hFFFF);
        wb(0, 8'h7C, 0, 32'hFFFF_0000);
        wb(0, 8'h40, 0, 32'hFFFF_0000);
        settle(2);
        chk({14'h0, pad_oe, pad_out}, 16'h2);
        $display("reserved and lanes done");
        wb(1, 8'h78, 16'h0080);
        irq <= 1'b1;
        pad_in <= 1'b0;
        settle(4);
        chk({13'h0, pad_oe, pad_out, pdown}, 16'h4);
        irq <= 1'b0;
        wb(1, 8'h78, 16'h0000);
        settle(4);
        chk({13'h0, pad_oe, pad_out, pdown}, 16'h3);
        pad_in <= 1'b1;
        settle(4);
        chk({15'h0, pdown}, 16'h0);
        $display("pad done");
        for (int k = 0; k < 8; k++) begin
            wb(1, 8'h94, 16'hFF1F | 16'(k << 5));
            wb(0, 8'h94, 0, {16'hFFFF, 16'h0400 | 16'(k << 5)});
            settle(1);
            chk({12'h0, pairs}, k > 3 ? 16'hF : 16'h1 << k);
        end
        $display("test pairs done");
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            fail_req <= f[0];
            dly <= 8'(8 + 12 * f);
            wb(1, 8'h78, 16'h0001);
            wb(0, 8'h78, 0, 32'h0006_0000);
            settle(30);
            wb(0, 8'h78, 0, {16'h0006, f ? 16'h6 : 16'h2});
        end
        $display("reflectometry done");
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            wb(1, 8'h78, {4'h0, r[4], 11'h0});
            {an, f100, forced_req, ieee} <= r[3:0];
            settle(3);
            chk({15'h0, fdx}, {15'h0, r[0] | r[4] & r[1] & (r[3] | r[2])});
        end
        $display("duplex done");
        wb(1, 8'hB0, 16'h1412);
        wb(1, 8'h7C, 16'h4000);
        settle(3);
        wb(0, 8'hB0, 0, 32'hFFFF_1412);
        wb(0, 8'h7C, 0, 32'hFFFF_0000);
        wb(1, 8'h7C, 16'h8000);
        settle(3);
        wb(0, 8'hB0, 0, 32'hFFFF_141F);
        wb(0, 8'h78, 0, 32'hFFFF_0002);
        $display("soft reset done");
        {link, an, f100, forced_req} <= 4'h3;
        wb(1, 8'h78, 16'h0200);
        wb(1, 8'hB0, 16'h1410);
        hunt_period(RS);
        wb(1, 8'hB0, 16'h1411);
        hunt_period(2 * RS);
        wb(1, 8'h78, 16'h0100);
        hunt_period(QH);
        wb(1, 8'h78, 16'h0000);
        hunt_period(0);
        an <= 1'b1;
        hunt_period(NH);
        $display("crossover done");
        give_verdict();
    end
    // over ten times the cycles the sequence above needs
    initial begin
        #(25 * 20000);
        fail_count++;
        give_verdict();
    end
endmodule

// ### hdl/phy_misc_pkg.sv
// constants and types for the phy miscellaneous control registers
package phy_misc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PHY_CONFIGURATION_THREE  = 8'h1E;
    localparam logic [7:0] IDX_CTRL  = 8'h1F;
    localparam logic [7:0] IDX_TMCH  = 8'h25;
    localparam logic [7:0] IDX_TIMER = 8'h2C;
    localparam int         ADDR_LSB  = 2;

    // configuration three fields
    localparam int BIT_FDX_EXT  = 11;
    localparam int BIT_ROBUST   = 9;
    localparam int BIT_QUICK    = 8;
    localparam int BIT_PAD_ROLE = 7;
    localparam int BIT_FORCE_IRQ = 6;
    localparam int BIT_CABLE_REFLECTOMETRY_FAILED = 2;
    localparam int BIT_CABLE_REFLECTOMETRY_COMPLETE = 1;
    localparam int BIT_TDR_GO   = 0;

    // global control fields
    localparam int BIT_FULL_SOFT_RESET   = 15;
    localparam int BIT_SOFT_RESTART_KEEP_REGS = 14;

    // test channel fields
    localparam int BIT_ALL_PAIRS = 7;
    localparam int PAIR_SEL_HI   = 6;
    localparam int PAIR_SEL_LO   = 5;
    localparam logic [7:0] TMCH_RSVD_HI = 8'h04;

    // crossover timer register reset values
    localparam logic [11:0] TIMER_RSVD_RESET = 12'h141;
    localparam logic [3:0]  TIMER_CODE_RESET = 4'hF;

    // timing
    localparam int CLK_HZ         = 40_000_000;
    localparam int ROBUST_STEP_MS = 32;
    localparam int NORMAL_HUNT_MS = 64;
    localparam int QUICK_HUNT_MS  = 4;
    localparam int ROBUST_STEP_CYCLES = ROBUST_STEP_MS * (CLK_HZ / 1000);
    localparam int NORMAL_HUNT_CYCLES = NORMAL_HUNT_MS * (CLK_HZ / 1000);
    localparam int QUICK_HUNT_CYCLES  = QUICK_HUNT_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic fdx_ext;
        logic robust;
        logic quick;
        logic pad_role;
        logic force_irq;
        logic cable_reflectometry_failed;
        logic cable_reflectometry_complete;
        logic tdr_go;
    } phy_configuration_three_type;

    localparam phy_configuration_three_type PHY_CONFIGURATION_THREE_RESET = '{
        fdx_ext: 1'b0, robust: 1'b0, quick: 1'b0, pad_role: 1'b0,
        force_irq: 1'b0, cable_reflectometry_failed: 1'b0, cable_reflectometry_complete: 1'b1, tdr_go: 1'b0};
endpackage

// ### hdl/phy_misc_regs.sv
// phy miscellaneous configuration and control register bank
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module phy_misc_regs #(
    parameter int ROBUST_STEP = phy_misc_pkg::ROBUST_STEP_CYCLES,
    parameter int NORMAL_HUNT = phy_misc_pkg::NORMAL_HUNT_CYCLES,
    parameter int QUICK_HUNT  = phy_misc_pkg::QUICK_HUNT_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        LOCAL_AUTONEG,
    input  wire logic        LOCAL_FORCED_100,
    input  wire logic        PARTNER_FORCED_100,
    input  wire logic        IEEE_FULL_DUPLEX,
    input  wire logic        LINK_UP,
    input  wire logic        IRQ_EVENT,
    input  wire logic        TDR_FINISHED,
    input  wire logic        TDR_FAILED,
    input  wire logic        PAD_IN,
    output logic             PAD_OUT,
    output logic             PAD_OE,
    output logic             POWER_DOWN,
    output logic             FULL_DUPLEX,
    output logic             MDI_CROSSED,
    output logic             TDR_RUN,
    output logic      [3:0]  TEST_PAIR_EN,
    output logic             SOFT_RESET,
    output logic             SOFT_RESTART
);
    initial begin
        if (ROBUST_STEP < 1)
            $error("robust step must be at least one cycle");
        if (NORMAL_HUNT < 1)
            $error("normal hunt period must be at least one cycle");
        if (QUICK_HUNT < 1)
            $error("quick hunt period must be at least one cycle");
        if (phy_misc_pkg::ADDR_LSB != 2)
            $error("register index decode expects word addressing");
        if (ROBUST_STEP > 268435455)
            $error("robust step too large for the period counter");
    end

    phy_misc_pkg::phy_configuration_three_type cfg;
    logic [2:0]  pair_sel;
    logic [11:0] timer_rsvd;
    logic [3:0]  timer_code;
    logic        full_soft_reset;
    logic        soft_restart_keep_regs;
    logic        pad_meta;
    logic        pad_sync;

    logic        req;
    logic        wr;
    logic [7:0]  idx;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [15:0] next_read;
    logic        launch;
    logic        device_reset;

    localparam int ADDR_LSB_W = phy_misc_pkg::ADDR_LSB;

    logic        hit_config;
    logic        hit_control;
    logic        hit_pairs;
    logic        hit_timer;

    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = req && WB_WE_I;
    assign idx = {2'b00, WB_ADR_I[7:ADDR_LSB_W]};
    assign wmask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign wdata = WB_DAT_I[15:0];

    // one decode per register keeps the write and strobe logic short
    assign hit_config = idx == phy_misc_pkg::IDX_PHY_CONFIGURATION_THREE;
    assign hit_control = idx == phy_misc_pkg::IDX_CTRL;
    assign hit_pairs = idx == phy_misc_pkg::IDX_TMCH;
    assign hit_timer = idx == phy_misc_pkg::IDX_TIMER;
    // a restart resets the engines; a full reset does too, plus registers
    assign device_reset = full_soft_reset || soft_restart_keep_regs;

    // launch only on a written one; a held one does not restart runs
    assign launch = wr && hit_config
        && WB_SEL_I[0] && wdata[phy_misc_pkg::BIT_TDR_GO];

    // bus answer: one ack per request, dropped the cycle after
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= req;
            if (req)
                WB_DAT_O <= {16'h0000, next_read};
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        next_read = 16'h0000;
        case (idx)
            phy_misc_pkg::IDX_PHY_CONFIGURATION_THREE: begin
                next_read[phy_misc_pkg::BIT_FDX_EXT] = cfg.fdx_ext;
                next_read[phy_misc_pkg::BIT_ROBUST] = cfg.robust;
                next_read[phy_misc_pkg::BIT_QUICK] = cfg.quick;
                next_read[phy_misc_pkg::BIT_PAD_ROLE] = cfg.pad_role;
                next_read[phy_misc_pkg::BIT_FORCE_IRQ] = cfg.force_irq;
                next_read[phy_misc_pkg::BIT_CABLE_REFLECTOMETRY_FAILED] = cfg.cable_reflectometry_failed;
                next_read[phy_misc_pkg::BIT_CABLE_REFLECTOMETRY_COMPLETE] = cfg.cable_reflectometry_complete;
                next_read[phy_misc_pkg::BIT_TDR_GO] = cfg.tdr_go;
            end
            // reserved bits simply never get a value
            phy_misc_pkg::IDX_CTRL: begin
                next_read[phy_misc_pkg::BIT_FULL_SOFT_RESET] = full_soft_reset;
                next_read[phy_misc_pkg::BIT_SOFT_RESTART_KEEP_REGS] = soft_restart_keep_regs;
            end
            phy_misc_pkg::IDX_TMCH: begin
                next_read[15:8] = phy_misc_pkg::TMCH_RSVD_HI;
                next_read[7:5] = pair_sel;
            end
            phy_misc_pkg::IDX_TIMER: begin
                next_read = {timer_rsvd, timer_code};
            end
            default: begin
                next_read = 16'h0000;
            end
        endcase
    end

    // self-clearing reset and restart strobes, one cycle each
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            full_soft_reset <= 1'b0;
            soft_restart_keep_regs <= 1'b0;
        end else begin
            full_soft_reset <= wr && hit_control && WB_SEL_I[1]
                && wdata[phy_misc_pkg::BIT_FULL_SOFT_RESET];
            soft_restart_keep_regs <= wr && hit_control
                && WB_SEL_I[1]
                && wdata[phy_misc_pkg::BIT_SOFT_RESTART_KEEP_REGS];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SOFT_RESET <= 1'b0;
            SOFT_RESTART <= 1'b0;
        end else begin
            SOFT_RESET <= full_soft_reset;
            SOFT_RESTART <= soft_restart_keep_regs;
        end
    end

    // writable configuration; full soft reset restores defaults
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg.fdx_ext <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.fdx_ext;
            cfg.robust <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.robust;
            cfg.quick <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.quick;
            cfg.pad_role <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.pad_role;
            cfg.force_irq <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.force_irq;
            cfg.tdr_go <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.tdr_go;
            pair_sel <= 3'h0;
            timer_rsvd <= phy_misc_pkg::TIMER_RSVD_RESET;
            timer_code <= phy_misc_pkg::TIMER_CODE_RESET;
        end else if (full_soft_reset) begin
            cfg.fdx_ext <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.fdx_ext;
            cfg.robust <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.robust;
            cfg.quick <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.quick;
            cfg.pad_role <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.pad_role;
            cfg.force_irq <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.force_irq;
            cfg.tdr_go <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.tdr_go;
            pair_sel <= 3'h0;
            timer_rsvd <= phy_misc_pkg::TIMER_RSVD_RESET;
            timer_code <= phy_misc_pkg::TIMER_CODE_RESET;
        end else if (wr) begin
            if (hit_config) begin
                if (WB_SEL_I[1])
                    cfg.fdx_ext <= wdata[phy_misc_pkg::BIT_FDX_EXT];
                if (WB_SEL_I[1])
                    cfg.robust <= wdata[phy_misc_pkg::BIT_ROBUST];
                if (WB_SEL_I[1])
                    cfg.quick <= wdata[phy_misc_pkg::BIT_QUICK];
                if (WB_SEL_I[0])
                    cfg.pad_role <= wdata[phy_misc_pkg::BIT_PAD_ROLE];
                if (WB_SEL_I[0])
                    cfg.force_irq <= wdata[phy_misc_pkg::BIT_FORCE_IRQ];
                if (WB_SEL_I[0])
                    cfg.tdr_go <= wdata[phy_misc_pkg::BIT_TDR_GO];
            end
            if (hit_pairs && WB_SEL_I[0])
                pair_sel <= wdata[7:5];
            if (hit_timer) begin
                timer_rsvd <= (timer_rsvd & ~wmask[15:4])
                    | (wdata[15:4] & wmask[15:4]);
                timer_code <= (timer_code & ~wmask[3:0])
                    | (wdata[3:0] & wmask[3:0]);
            end
        end
    end

    // reflectometry status: finish wins over a launch in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg.cable_reflectometry_complete <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.cable_reflectometry_complete;
            cfg.cable_reflectometry_failed <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.cable_reflectometry_failed;
            TDR_RUN <= 1'b0;
        end else if (device_reset) begin
            cfg.cable_reflectometry_complete <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.cable_reflectometry_complete;
            cfg.cable_reflectometry_failed <= phy_misc_pkg::PHY_CONFIGURATION_THREE_RESET.cable_reflectometry_failed;
            TDR_RUN <= 1'b0;
        end else if (TDR_RUN && TDR_FINISHED) begin
            cfg.cable_reflectometry_complete <= 1'b1;
            cfg.cable_reflectometry_failed <= TDR_FAILED;
            TDR_RUN <= 1'b0;
        end else if (launch) begin
            cfg.cable_reflectometry_complete <= 1'b0;
            cfg.cable_reflectometry_failed <= 1'b0;
            TDR_RUN <= 1'b1;
        end
    end

    // duplex resolution
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            FULL_DUPLEX <= 1'b0;
        else if (cfg.fdx_ext && PARTNER_FORCED_100
                 && (LOCAL_AUTONEG || LOCAL_FORCED_100))
            FULL_DUPLEX <= 1'b1;
        else
            FULL_DUPLEX <= IEEE_FULL_DUPLEX;
    end

    // crossover hunting: swap pairs each period until link comes up
    logic [31:0] hunt_count;
    logic [31:0] hunt_limit;
    logic        quick_case;
    logic        hunting;

    assign quick_case = cfg.quick && LOCAL_FORCED_100 && !LOCAL_AUTONEG;
    // plain hunting needs negotiation; robust hunts in every mode
    assign hunting = !LINK_UP
        && (LOCAL_AUTONEG || cfg.robust || quick_case);

    always_comb begin
        if (quick_case)
            hunt_limit = 32'(QUICK_HUNT);
        else if (cfg.robust)
            hunt_limit = 32'(ROBUST_STEP) * {28'h0, timer_code}
                + 32'(ROBUST_STEP);
        else
            hunt_limit = 32'(NORMAL_HUNT);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            hunt_count <= 32'h0000_0000;
            MDI_CROSSED <= 1'b0;
        end else if (device_reset || !hunting) begin
            hunt_count <= 32'h0000_0000;
            if (device_reset)
                MDI_CROSSED <= 1'b0;
        end else if (hunt_count + 32'h0000_0001 >= hunt_limit) begin
            hunt_count <= 32'h0000_0000;
            MDI_CROSSED <= !MDI_CROSSED;
        end else begin
            hunt_count <= hunt_count + 32'h0000_0001;
        end
    end

    // test mode pair enables
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            TEST_PAIR_EN <= 4'h0;
        else if (pair_sel[2])
            TEST_PAIR_EN <= 4'hF;
        else begin
            // explicit table so pair order A to D is plain to see
            case (pair_sel[1:0])
                2'h0: TEST_PAIR_EN <= 4'h1;
                2'h1: TEST_PAIR_EN <= 4'h2;
                2'h2: TEST_PAIR_EN <= 4'h4;
                2'h3: TEST_PAIR_EN <= 4'h8;
                default: TEST_PAIR_EN <= 4'h0;
            endcase
        end
    end

    // shared pad; the input is a pin so it is synchronised first
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pad_meta <= 1'b1;
            pad_sync <= 1'b1;
        end else begin
            pad_meta <= PAD_IN;
            pad_sync <= pad_meta;
        end
    end

    // pad is active low in both roles; drives only as an interrupt
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PAD_OE <= 1'b0;
            PAD_OUT <= 1'b1;
            POWER_DOWN <= 1'b0;
        end else begin
            PAD_OE <= cfg.pad_role;
            PAD_OUT <= !(cfg.force_irq || IRQ_EVENT);
            POWER_DOWN <= !cfg.pad_role && !pad_sync;
        end
    end
endmodule
